// [cpu_core_defs.svh]
// Constants of the 8-bit load/store datapath core.
// Summary of operation
// - Next instruction is fetched while the current one executes.
// - Register-register and register-immediate arithmetic finishes in one cycle, written back.
// - Result flags are updated after every arithmetic or logic operation.
// - Thirty-two byte-wide working registers, single-cycle read and write.
// - Registers 26 to 31 form three 16-bit pointers.
// - Program bus addresses Flash directly, first word at address zero.
// - Peripheral registers occupy the lowest 4KB of data space.
// - First 64 I/O locations reachable by short transfers and by loads/stores.
// - First 32 I/O locations support bit set/clear and bit test-and-skip.
// - I/O 0x0040 to 0x0FFF reachable only through loads and stores.
// - Data 0x1000 up to 0x1800 is the fuse, NVM controller and EEPROM region.
// - Data 0x1800 to 0x7FFF is the SRAM and other memory region.
// - Flash appears in data space from 0x8000 upward.
// - Program-space byte load reads Flash with code addressing from zero.
// - Multiplier takes two bytes and yields a 16-bit product.
// - Signed, unsigned, mixed, integer and fractional products are supported.
// - Every multiplication takes two clock cycles.
// - Data addresses are 16 bits, covering 64KB directly.
// - Sixteen-bit I/O accesses move both bytes as one transfer.
// - The ALU does both 8-bit and 16-bit arithmetic.
// - After reset execution starts at program address zero.
// - The core runs on the core clock with no division.
`ifndef CPU_CORE_DEFS_SVH
`define CPU_CORE_DEFS_SVH
`define RESET_PC      16'h0000
`define NVM_BASE      16'h1000
`define SRAM_BASE     16'h1800
`define FLASH_BASE    16'h8000
`define OP_ADD        4'h1
`define OP_SUB        4'h2
`define OP_AND        4'h3
`define OP_EOR        4'h4
`define OP_MOV        4'h5
`define OP_ADDI       4'h6
`define OP_SUBI       4'h7
`define OP_LDI        4'h8
`define OP_WADD       4'h9
`define OP_MUL        4'ha
`define OP_IO         4'hb
`define OP_IOBIT      4'hc
`define OP_LOAD       4'hd
`define OP_STORE      4'he
`define OP_PLOAD      4'hf
`define PTR_BASE      5'd26
`define WADD_BASE     5'd24
`define PROD_LO       5'd0
`define PROD_HI       5'd1
`define FLAG_C        0
`define FLAG_Z        1
`define FLAG_N        2
`define FLAG_V        3
`endif

// [cpu_core_pkg.sv]
// Types shared by the datapath core.
package cpu_core_pkg;
  typedef enum logic [1:0] {REG_IO, REG_NVM, REG_SRAM, REG_FLASH} region_e;
  typedef enum logic [1:0] {S_RUN, S_LOAD, S_PROG, S_MUL} state_e;
  typedef struct packed {
    logic [31:0][7:0] regs;
    logic [15:0]      progAddr;
    logic [15:0]      savedPc;
    logic [15:0]      instr;
    logic             instrValid;
    state_e           st;
    logic [3:0]       flags;
    logic [15:0]      mulProd;
    logic             mulCarry;
    logic             byteSel;
    logic [15:0]      rdAddr;
    logic             rdEn;
    logic             rdWide;
    region_e          rdRegion;
    logic [15:0]      wrAddr;
    logic [15:0]      wrData;
    logic             wrEn;
    logic             wrWide;
    region_e          wrRegion;
  } core_s;
endpackage

// [cpu_datapath.sv]
// Fetch/execute datapath with register file, ALU, multiplier and data-space decoder.
`timescale 1ns/10ps
`include "cpu_core_defs.svh"
module cpu_datapath
  import cpu_core_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Program memory, read data valid in the cycle the address is shown.
  output logic [15:0]      progAddr,
  input  wire logic [15:0] progData,
  // Data space read port.
  output logic [15:0]      dataRdAddr,
  output logic             dataRdEn,
  output logic             dataRdWide,
  output region_e          dataRdRegion,
  input  wire logic [15:0] dataRdata,
  // Data space write port, committed at the end of the cycle it is shown.
  output logic [15:0]      dataWrAddr,
  output logic [15:0]      dataWrData,
  output logic             dataWrEn,
  output logic             dataWrWide,
  output region_e          dataWrRegion,
  // Result flags, bit 0 carry, 1 zero, 2 negative, 3 overflow.
  output logic [3:0]       aluFlags
);

  // ==========================================================================
  // Functions
  // ==========================================================================

  // Data-space region decoder over the full 16-bit address.
  function automatic region_e regionOf(input logic [15:0] a);
    if (a < `NVM_BASE) begin
      return REG_IO;
    end else if (a < `SRAM_BASE) begin
      return REG_NVM;
    end else if (a < `FLASH_BASE) begin
      return REG_SRAM;
    end else begin
      return REG_FLASH;
    end
  endfunction

  // Byte add or subtract, returns {V,N,Z,C,result}.
  function automatic logic [11:0] arith8(input logic [7:0] a, input logic [7:0] b, input logic sub);
    logic [8:0] r;
    logic       v;
    r = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
    v = sub ? ((a[7] ^ b[7]) & (a[7] ^ r[7])) : (~(a[7] ^ b[7]) & (a[7] ^ r[7]));
    return {v, r[7], r[7:0] == 8'h00, r[8], r[7:0]};
  endfunction

  // ==========================================================================
  // State and field decode
  // ==========================================================================

  core_s s;
  core_s next_s;

  logic [3:0]  op;
  logic [4:0]  rd;
  logic [4:0]  rr;
  logic [4:0]  rdHi;
  logic [4:0]  ptrLo;
  logic [15:0] ptrVal;
  logic [15:0] loadData;
  logic [3:0]  fetchOp;

  // Field decode of the executing word; immediate forms use registers 16 to 31.
  assign op      = s.instr[15:12];
  assign rd      = s.instr[11:7];
  assign rr      = s.instr[6:2];
  assign rdHi    = {1'b1, s.instr[11:8]};
  assign ptrLo   = 5'(`PTR_BASE + {s.instr[6:5], 1'b0});
  assign ptrVal  = {s.regs[5'(ptrLo + 5'd1)], s.regs[ptrLo]};
  assign fetchOp = progData[15:12];
  // A read of the location being written this cycle would see the old value, so forward it.
  assign loadData = (s.wrEn && s.wrAddr == s.rdAddr) ? s.wrData : dataRdata;

  // ==========================================================================
  // Next-state logic
  // ==========================================================================

  logic              doFetch;
  logic              skip;
  logic [11:0]       ar;
  logic [16:0]       w;
  logic [4:0]        wLo;
  logic [7:0]        b8;
  logic signed [17:0] prod;
  logic              sa;
  logic              sb;
  logic [15:0]       pNext;

  // One pass decides execution of the current word and the fetch of the next.
  always_comb begin
    next_s  = s;
    doFetch = 1'b1;
    skip    = 1'b0;
    ar      = '0;
    w       = '0;
    wLo     = 5'(`WADD_BASE + {s.instr[11:10], 1'b0});
    b8      = '0;
    prod    = '0;
    sa      = 1'b0;
    sb      = 1'b0;
    pNext   = ptrVal + (s.instr[3] ? 16'h0002 : 16'h0001);
    next_s.rdEn   = 1'b0;
    next_s.rdWide = 1'b0;
    next_s.wrEn   = 1'b0;
    next_s.wrWide = 1'b0;
    case (s.st)
      S_RUN: begin
        if (s.instrValid) begin
          case (op)
            `OP_ADD, `OP_SUB: begin
              ar = arith8(s.regs[rd], s.regs[rr], op == `OP_SUB);
              next_s.regs[rd] = ar[7:0];
              next_s.flags    = ar[11:8];
            end
            `OP_ADDI, `OP_SUBI: begin
              ar = arith8(s.regs[rdHi], s.instr[7:0], op == `OP_SUBI);
              next_s.regs[rdHi] = ar[7:0];
              next_s.flags      = ar[11:8];
            end
            `OP_AND, `OP_EOR: begin
              b8 = (op == `OP_AND) ? (s.regs[rd] & s.regs[rr]) : (s.regs[rd] ^ s.regs[rr]);
              next_s.regs[rd]           = b8;
              next_s.flags[`FLAG_Z]     = b8 == 8'h00;
              next_s.flags[`FLAG_N]     = b8[7];
              next_s.flags[`FLAG_V]     = 1'b0;
            end
            `OP_MOV: next_s.regs[rd] = s.regs[rr];
            `OP_LDI: next_s.regs[rdHi] = s.instr[7:0];
            `OP_WADD: begin
              // Word add or subtract of a 6-bit constant on one of four register pairs.
              if (s.instr[9]) begin
                w = {1'b0, s.regs[5'(wLo + 5'd1)], s.regs[wLo]} - {11'h000, s.instr[5:0]};
              end else begin
                w = {1'b0, s.regs[5'(wLo + 5'd1)], s.regs[wLo]} + {11'h000, s.instr[5:0]};
              end
              next_s.regs[wLo]             = w[7:0];
              next_s.regs[5'(wLo + 5'd1)]  = w[15:8];
              next_s.flags[`FLAG_C]        = w[16];
              next_s.flags[`FLAG_Z]        = w[15:0] == 16'h0000;
              next_s.flags[`FLAG_N]        = w[15];
              next_s.flags[`FLAG_V]        = s.instr[9] ? (s.regs[5'(wLo + 5'd1)][7] & ~w[15])
                                                        : (~s.regs[5'(wLo + 5'd1)][7] & w[15]);
            end
            `OP_MUL: begin
              // Variants 0..2 integer uu, ss, su; 3..5 the same as fractional.
              sa = s.instr[10:8] inside {3'd1, 3'd2, 3'd4, 3'd5};
              sb = s.instr[10:8] inside {3'd1, 3'd4};
              prod = $signed({sa & s.regs[{1'b1, s.instr[7:4]}][7], s.regs[{1'b1, s.instr[7:4]}]})
                   * $signed({sb & s.regs[{1'b1, s.instr[3:0]}][7], s.regs[{1'b1, s.instr[3:0]}]});
              next_s.mulCarry = prod[15];
              next_s.mulProd  = (s.instr[10:8] >= 3'd3) ? {prod[14:0], 1'b0} : prod[15:0];
              next_s.st       = S_MUL;
              doFetch         = 1'b0;
            end
            `OP_IO: begin
              if (s.instr[11]) begin
                next_s.wrAddr   = {10'h000, s.instr[10:5]};
                next_s.wrData   = {8'h00, s.regs[s.instr[4:0]]};
                next_s.wrEn     = 1'b1;
                next_s.wrRegion = REG_IO;
              end else begin
                next_s.regs[s.instr[4:0]] = loadData[7:0];
              end
            end
            `OP_IOBIT: begin
              b8 = loadData[7:0];
              if (s.instr[11]) begin
                skip = b8[s.instr[2:0]] == s.instr[10];
              end else begin
                b8[s.instr[2:0]] = ~s.instr[10];
                next_s.wrAddr   = {11'h000, s.instr[9:5]};
                next_s.wrData   = {8'h00, b8};
                next_s.wrEn     = 1'b1;
                next_s.wrRegion = REG_IO;
              end
            end
            `OP_LOAD: begin
              doFetch = 1'b0;
              if (regionOf(ptrVal) == REG_FLASH) begin
                next_s.savedPc  = s.progAddr;
                next_s.progAddr = {2'b00, ptrVal[14:1]};
                next_s.byteSel  = ptrVal[0];
                next_s.rdWide   = s.instr[3];
                next_s.st       = S_PROG;
              end else begin
                next_s.rdAddr   = ptrVal;
                next_s.rdEn     = 1'b1;
                next_s.rdWide   = s.instr[3];
                next_s.rdRegion = regionOf(ptrVal);
                next_s.st       = S_LOAD;
              end
              if (s.instr[4]) begin
                next_s.regs[ptrLo]             = pNext[7:0];
                next_s.regs[5'(ptrLo + 5'd1)]  = pNext[15:8];
              end
            end
            `OP_STORE: begin
              next_s.wrAddr   = ptrVal;
              next_s.wrData   = s.instr[3] ? {s.regs[5'(rd + 5'd1)], s.regs[rd]} : {8'h00, s.regs[rd]};
              next_s.wrEn     = 1'b1;
              next_s.wrWide   = s.instr[3];
              next_s.wrRegion = regionOf(ptrVal);
              if (s.instr[4]) begin
                next_s.regs[ptrLo]             = pNext[7:0];
                next_s.regs[5'(ptrLo + 5'd1)]  = pNext[15:8];
              end
            end
            `OP_PLOAD: begin
              // Code addressing: the Z pair is a byte address counted from word zero.
              doFetch         = 1'b0;
              next_s.savedPc  = s.progAddr;
              next_s.progAddr = {1'b0, s.regs[5'd31], s.regs[5'd30][7:1]};
              next_s.byteSel  = s.regs[5'd30][0];
              next_s.rdWide   = 1'b0;
              next_s.st       = S_PROG;
              if (s.instr[4]) begin
                {next_s.regs[5'd31], next_s.regs[5'd30]} = {s.regs[5'd31], s.regs[5'd30]} + 16'h0001;
              end
            end
            default: ;
          endcase
        end
      end
      S_LOAD: begin
        next_s.regs[rd] = loadData[7:0];
        if (s.rdWide) begin
          next_s.regs[5'(rd + 5'd1)] = loadData[15:8];
        end
        next_s.st = S_RUN;
      end
      S_PROG: begin
        // The fetch address was borrowed, so the word now on the bus is not an instruction.
        next_s.regs[rd] = s.byteSel ? progData[15:8] : progData[7:0];
        if (s.rdWide) begin
          next_s.regs[5'(rd + 5'd1)] = progData[15:8];
          next_s.regs[rd]            = progData[7:0];
        end
        next_s.progAddr   = s.savedPc;
        next_s.instrValid = 1'b0;
        next_s.st         = S_RUN;
        doFetch           = 1'b0;
      end
      S_MUL: begin
        next_s.regs[`PROD_LO]  = s.mulProd[7:0];
        next_s.regs[`PROD_HI]  = s.mulProd[15:8];
        next_s.flags[`FLAG_C]  = s.mulCarry;
        next_s.flags[`FLAG_Z]  = s.mulProd == 16'h0000;
        next_s.st              = S_RUN;
      end
      default: next_s.st = S_RUN;
    endcase
    // Fetch overlaps execution; the short I/O read address is decoded from the fetched word.
    if (doFetch) begin
      next_s.instr      = progData;
      next_s.instrValid = ~skip;
      next_s.progAddr   = s.progAddr + 16'h0001;
      // Every bit op reads first, else set and clear would write back stale neighbour bits.
      if ((fetchOp == `OP_IO && !progData[11]) || fetchOp == `OP_IOBIT) begin
        next_s.rdAddr   = (fetchOp == `OP_IO) ? {10'h000, progData[10:5]} : {11'h000, progData[9:5]};
        next_s.rdEn     = 1'b1;
        next_s.rdRegion = REG_IO;
      end
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================

  // Reset clears the whole state; the bubble lets word zero arrive first.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s          <= '0;
      s.progAddr <= `RESET_PC;
    end else begin
      s <= next_s;
    end
  end

  // Outputs are flip-flop fields of the state.
  assign progAddr     = s.progAddr;
  assign dataRdAddr   = s.rdAddr;
  assign dataRdEn     = s.rdEn;
  assign dataRdWide   = s.rdWide;
  assign dataRdRegion = s.rdRegion;
  assign dataWrAddr   = s.wrAddr;
  assign dataWrData   = s.wrData;
  assign dataWrEn     = s.wrEn;
  assign dataWrWide   = s.wrWide;
  assign dataWrRegion = s.wrRegion;
  assign aluFlags     = s.flags;

  // ==========================================================================
  // Assertions
  // ==========================================================================

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence addExec;
    s.st == S_RUN && s.instrValid && op == `OP_ADD;
  endsequence
  sequence mulExec;
    s.st == S_RUN && s.instrValid && op == `OP_MUL;
  endsequence

  a_reset_start: assert property (disable iff (1'b0) rst |=> progAddr == 16'h0000 && !s.instrValid)
    else $error("Fetch does not restart at zero after reset.");
  a_fetch_overlap: assert property (!rst && s.st == S_RUN && (!s.instrValid || op < `OP_MUL
    || op == `OP_IO || op == `OP_IOBIT || op == `OP_STORE) |=> progAddr == $past(progAddr) + 16'h0001)
    else $error("Fetch did not advance while executing.");
  a_add_result: assert property (addExec |=> s.regs[$past(rd)] == 8'($past(s.regs[rd]) + $past(s.regs[rr])))
    else $error("Register add result wrong.");
  a_add_flags: assert property (addExec |=> aluFlags[`FLAG_Z] == (s.regs[$past(rd)] == 8'h00))
    else $error("Zero flag does not match result.");
  a_mul_two: assert property (mulExec |=> s.st == S_MUL ##1 (s.st == S_RUN
    && s.regs[0] == $past(s.mulProd[7:0]) && s.regs[1] == $past(s.mulProd[15:8])))
    else $error("Product not written two cycles after issue.");
  a_short_io: assert property (dataRdEn && dataRdRegion == REG_IO && s.st != S_LOAD |-> dataRdAddr < 16'h0040)
    else $error("Short I/O read outside the first 64 locations.");
  a_flash_map: assert property (s.st == S_RUN && s.instrValid && op == `OP_LOAD && ptrVal >= 16'h8000
    |=> s.st == S_PROG && progAddr == {2'b00, $past(ptrVal[14:1])})
    else $error("Flash data-space load not redirected to the program bus.");
  a_wide_store: assert property (s.st == S_RUN && s.instrValid && op == `OP_STORE && s.instr[3]
    |=> dataWrWide && dataWrEn && dataWrData == {$past(s.regs[5'(rd + 5'd1)]), $past(s.regs[rd])})
    else $error("Sixteen-bit store split or wrong.");
  a_region_io: assert property (dataWrEn && dataWrAddr < 16'h1000 |-> dataWrRegion == REG_IO)
    else $error("Low 4KB write not decoded as I/O.");
  a_bit_read: assert property (s.st == S_RUN && s.instrValid && op == `OP_IOBIT
    |-> dataRdEn && dataRdAddr == {11'h000, s.instr[9:5]})
    else $error("Bit operation did not read its location.");
  a_bit_write: assert property (s.st == S_RUN && s.instrValid && op == `OP_IOBIT && !s.instr[11]
    |=> dataWrEn && dataWrData[$past(s.instr[2:0])] == !$past(s.instr[10]))
    else $error("Bit set or clear wrote the wrong value.");

endmodule

// [mem_model.sv]
// Behavioural program memory and data space that sit on the far side of the datapath core.
`timescale 1ns/10ps
module mem_model
  import cpu_core_pkg::*;
(
  // Clock.
  input  wire logic        ref_clk,
  // Program memory.
  input  wire logic [15:0] progAddr,
  output logic [15:0]      progData,
  // Data space read port.
  input  wire logic [15:0] dataRdAddr,
  input  wire logic        dataRdEn,
  input  wire logic        dataRdWide,
  output logic [15:0]      dataRdata,
  // Data space write port.
  input  wire logic [15:0] dataWrAddr,
  input  wire logic [15:0] dataWrData,
  input  wire logic        dataWrEn,
  input  wire logic        dataWrWide
);
  // ==========================================================================
  // Storage
  logic [15:0] prog   [0:255];
  logic [7:0]  mem    [0:65535];
  logic [15:0] lastRd = 16'h0000;

  // Flash shows from 0x8000 upward, even bytes in the low half of a word.
  function automatic logic [7:0] rdByte(input logic [15:0] a);
    logic [15:0] w;
    w = prog[a[8:1]];
    if (a[15]) return a[0] ? w[15:8] : w[7:0];
    return mem[a];
  endfunction

  // The program bus reads Flash directly with word addressing from zero.
  assign progData = prog[progAddr[7:0]];

  // An idle read bus shows the inverse of its last value, so a late sample never matches by luck.
  always_comb begin
    if (dataRdEn) dataRdata = dataRdWide ? {rdByte(dataRdAddr + 16'h0001), rdByte(dataRdAddr)}
                                         : {~rdByte(dataRdAddr), rdByte(dataRdAddr)};
    else dataRdata = ~lastRd;
  end

  // Writes commit at the edge ending the enable cycle; Flash is not writable from data space.
  always @(posedge ref_clk) begin
    if (dataRdEn) lastRd <= dataRdata;
    if (dataWrEn && !dataWrAddr[15]) begin
      mem[dataWrAddr] <= dataWrData[7:0];
      if (dataWrWide) mem[dataWrAddr + 16'h0001] <= dataWrData[15:8];
    end
  end

  // Blank data space so read-modify-write steps start from a known value.
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
  end
endmodule

// [cpu_datapath_memory_map_test.sv]
// Self-checking bench that runs small programs on the datapath core against the memory model.
`timescale 1ns/10ps
`include "cpu_core_defs.svh"
module cpu_datapath_memory_map_test
  import cpu_core_pkg::*;
();
  // ==========================================================================
  // Signals
  typedef struct packed {
    logic [3:0]  op;
    logic [2:0]  mode;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [15:0] res;
    logic [3:0]  flg;
  } row_s;
  logic        ref_clk = 1'b0;
  logic        rst;
  logic [15:0] progAddr, progData, dataRdAddr, dataRdata, dataWrAddr, dataWrData;
  logic        dataRdEn, dataRdWide, dataWrEn, dataWrWide;
  region_e     dataRdRegion, dataWrRegion;
  logic [3:0]  aluFlags;
  logic [15:0] wrAddrQ [$];
  logic [15:0] wrDataQ [$];
  logic        wrWideQ [$];
  region_e     wrRegQ  [$];
  int          fails = 0;
  int          checksDone = 0;
  int          pc;
  logic [15:0] codeWord;
  logic [17:0] wideRd;
  region_e     sweepReg [8] = '{REG_IO, REG_IO, REG_NVM, REG_NVM, REG_SRAM, REG_SRAM, REG_FLASH, REG_FLASH};
  logic [15:0] sweep [8] = '{16'h0040, 16'h0fff, 16'h1000, 16'h17ff, 16'h1800, 16'h7fff, 16'h8000, 16'hffff};
  row_s        rows [17] = '{
    '{`OP_ADD, 3'h0, 8'hff, 8'h01, 16'h0000, 4'h3}, '{`OP_ADD, 3'h0, 8'h7f, 8'h01, 16'h0080, 4'hc},
    '{`OP_SUB, 3'h0, 8'h00, 8'h01, 16'h00ff, 4'h5}, '{`OP_SUB, 3'h0, 8'h80, 8'h01, 16'h007f, 4'h8},
    '{`OP_AND, 3'h0, 8'hf0, 8'h0f, 16'h0000, 4'h2}, '{`OP_EOR, 3'h0, 8'haa, 8'hff, 16'h0055, 4'h0},
    '{`OP_MOV, 3'h0, 8'h11, 8'h22, 16'h0022, 4'h0}, '{`OP_ADDI, 3'h0, 8'h0f, 8'h01, 16'h0010, 4'h0},
    '{`OP_SUBI, 3'h0, 8'h05, 8'h05, 16'h0000, 4'h2}, '{`OP_LDI, 3'h0, 8'h33, 8'h44, 16'h0044, 4'h0},
    '{`OP_MUL, 3'h0, 8'hff, 8'hff, 16'hfe01, 4'h1}, '{`OP_MUL, 3'h1, 8'hff, 8'hff, 16'h0001, 4'h0},
    '{`OP_MUL, 3'h2, 8'hff, 8'hff, 16'hff01, 4'h1}, '{`OP_MUL, 3'h3, 8'h80, 8'h80, 16'h8000, 4'h0},
    '{`OP_MUL, 3'h4, 8'hc0, 8'h40, 16'he000, 4'h1}, '{`OP_MUL, 3'h5, 8'hc0, 8'h80, 16'hc000, 4'h1},
    '{`OP_MUL, 3'h0, 8'h00, 8'h37, 16'h0000, 4'h2}};

  // ==========================================================================
  // Design and memory model
  cpu_datapath u_cpu_datapath (.ref_clk(ref_clk), .rst(rst), .progAddr(progAddr), .progData(progData),
    .dataRdAddr(dataRdAddr), .dataRdEn(dataRdEn), .dataRdWide(dataRdWide), .dataRdRegion(dataRdRegion),
    .dataRdata(dataRdata), .dataWrAddr(dataWrAddr), .dataWrData(dataWrData), .dataWrEn(dataWrEn),
    .dataWrWide(dataWrWide), .dataWrRegion(dataWrRegion), .aluFlags(aluFlags));
  mem_model u_mem_model (.ref_clk(ref_clk), .progAddr(progAddr), .progData(progData), .dataRdAddr(dataRdAddr),
    .dataRdEn(dataRdEn), .dataRdWide(dataRdWide), .dataRdata(dataRdata), .dataWrAddr(dataWrAddr),
    .dataWrData(dataWrData), .dataWrEn(dataWrEn), .dataWrWide(dataWrWide));

  // Free-running core clock at 100 MHz.
  always #5 ref_clk = ~ref_clk;

  // Every committed write and the last wide read are logged so region and width can be judged afterwards.
  always @(posedge ref_clk) begin
    if (rst === 1'b0 && dataWrEn === 1'b1) begin
      wrAddrQ.push_back(dataWrAddr);
      wrDataQ.push_back(dataWrData);
      wrWideQ.push_back(dataWrWide);
      wrRegQ.push_back(dataWrRegion);
    end
    if (rst === 1'b0 && dataRdEn === 1'b1 && dataRdWide === 1'b1) wideRd <= {dataRdRegion, dataRdAddr};
  end

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] ldi(input logic [4:0] r, input logic [7:0] v);
    return {`OP_LDI, r[3:0], v};
  endfunction
  function automatic logic [15:0] out(input logic [5:0] io, input logic [4:0] r);
    return {`OP_IO, 1'b1, io, r};
  endfunction
  function automatic logic [15:0] ldst(input logic [3:0] op, input logic [4:0] r, input logic [1:0] p,
                                       input logic w);
    return {op, r, p, 1'b0, w, 3'h0};
  endfunction
  function automatic logic [7:0] m(input logic [15:0] a);
    return u_mem_model.mem[a];
  endfunction

  task automatic emit(input logic [15:0] w);
    u_mem_model.prog[pc] = w;
    pc++;
  endtask
  task automatic clear_prog();
    for (int i = 0; i < 256; i++) u_mem_model.prog[i] = 16'h0000;
    pc = 0;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("Checks done %0d, mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Reset the core, release it and run until the write to doneAddr shows, bounded.
  task automatic run_prog(input int expN, input logic [15:0] doneAddr);
    int n;
    @(posedge ref_clk) rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk("progAddr in reset", 16'h0000, progAddr);
    @(posedge ref_clk) rst <= 1'b0;
    for (n = 1; n <= 200; n++) begin
      @(posedge ref_clk);
      #1;
      if (n <= 3) chk("progAddr step", 16'(n), progAddr);
      if (dataWrEn === 1'b1 && dataWrAddr === doneAddr) break;
    end
    if (n > 200) begin
      fails++;
      print_verdict();
    end
    if (expN != 0) chk("cycles to result", 16'(expN), 16'(n));
    @(posedge ref_clk);
    #1;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 chk("progAddr at start", `RESET_PC, progAddr);
    // Table rows: load two operands, operate, then send the result out through short writes.
    foreach (rows[i]) begin
      clear_prog();
      emit(ldi(5'd16, rows[i].a));
      emit(ldi(5'd17, rows[i].b));
      if (rows[i].op == `OP_MUL) emit({`OP_MUL, 1'b0, rows[i].mode, 8'h01});
      else if (rows[i].op >= `OP_ADDI) emit({rows[i].op, 4'h0, rows[i].b});
      else emit({rows[i].op, 5'd16, 5'd17, 2'b00});
      emit(out(6'h10, rows[i].op == `OP_MUL ? `PROD_LO : 5'd16));
      emit(out(6'h11, `PROD_HI));
      u_mem_model.mem[16'h0010] = 8'hee;
      u_mem_model.mem[16'h0011] = 8'hee;
      run_prog(rows[i].op == `OP_MUL ? 7 : 6, 16'h0011);
      chk("result", rows[i].res, {m(16'h0011), m(16'h0010)});
      chk("flags", {12'h000, rows[i].flg}, {12'h000, aluFlags});
    end
    // Region sweep at every boundary, wide pointer traffic, code loads, short I/O, bit ops, word add.
    clear_prog();
    foreach (sweep[k]) begin
      emit(ldi(5'd30, sweep[k][7:0]));
      emit(ldi(5'd31, sweep[k][15:8]));
      emit(ldst(`OP_STORE, 5'd16, 2'd2, 1'b0));
    end
    emit(ldi(5'd16, 8'h34));
    emit(ldi(5'd17, 8'h12));
    emit(ldi(5'd26, 8'h00));
    emit(ldi(5'd27, 8'h19));
    emit(ldst(`OP_STORE, 5'd16, 2'd0, 1'b1));
    emit(ldst(`OP_LOAD, 5'd18, 2'd0, 1'b1));
    emit(out(6'h12, 5'd18));
    emit(out(6'h13, 5'd19));
    emit(ldi(5'd30, 8'h03));
    emit(ldi(5'd31, 8'h00));
    emit({`OP_PLOAD, 5'd20, 7'h10});
    emit(out(6'h14, 5'd20));
    emit(ldi(5'd31, 8'h80));
    emit(ldst(`OP_LOAD, 5'd21, 2'd2, 1'b0));
    emit(out(6'h15, 5'd21));
    emit({`OP_IO, 1'b0, 6'h3f, 5'd22});
    emit(out(6'h16, 5'd22));
    emit({`OP_IOBIT, 2'b00, 5'h1f, 2'b00, 3'h7});
    emit({`OP_IOBIT, 2'b11, 5'h1f, 2'b00, 3'h7});
    emit(ldi(5'd23, 8'h01));
    emit({`OP_IOBIT, 2'b01, 5'h1e, 2'b00, 3'h0});
    emit({`OP_IOBIT, 2'b10, 5'h1e, 2'b00, 3'h0});
    emit(ldi(5'd23, 8'h02));
    emit(out(6'h17, 5'd23));
    emit(ldi(5'd24, 8'hff));
    emit(ldi(5'd25, 8'h00));
    emit({`OP_WADD, 2'b00, 1'b0, 3'h0, 6'h01});
    emit(out(6'h18, 5'd24));
    emit(out(6'h19, 5'd25));
    codeWord = u_mem_model.prog[1];
    for (int a = 16'h12; a <= 16'h19; a++) u_mem_model.mem[a] = 8'hee;
    u_mem_model.mem[16'h003f] = 8'h5a;
    u_mem_model.mem[16'h001f] = 8'h00;
    u_mem_model.mem[16'h001e] = 8'hff;
    wrAddrQ.delete();
    wrDataQ.delete();
    wrWideQ.delete();
    wrRegQ.delete();
    run_prog(0, 16'h0019);
    foreach (sweep[k]) begin
      chk("store address", sweep[k], wrAddrQ[k]);
      chk("store region", {14'h0000, sweepReg[k]}, {14'h0000, wrRegQ[k]});
    end
    chk("wide store data", 16'h1234, wrDataQ[8]);
    chk("wide store flag", 16'h0001, {15'h0000, wrWideQ[8]});
    chk("wide load", 16'h1234, {m(16'h0013), m(16'h0012)});
    chk("code byte load", {8'h00, codeWord[15:8]}, {8'h00, m(16'h0014)});
    chk("flash data load", {8'h00, u_mem_model.prog[2][7:0]}, {8'h00, m(16'h0015)});
    chk("short read", 16'h005a, {8'h00, m(16'h0016)});
    chk("bit set", 16'h0080, {8'h00, m(16'h001f)});
    chk("bit skip", 16'h0000, {8'h00, m(16'h0017)});
    chk("bit clear", 16'h00fe, {8'h00, m(16'h001e)});
    chk("wide read address", 16'h1900, wideRd[15:0]);
    chk("wide read region", {14'h0000, REG_SRAM}, {14'h0000, wideRd[17:16]});
    chk("word add", 16'h0100, {m(16'h0019), m(16'h0018)});
    chk("word flags", 16'h0000, {12'h000, aluFlags});
    print_verdict();
  end
endmodule
